// *** verilog/edh_pkg.sv ***
`default_nettype none
package edh_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int SETUP_NS = 5;
   localparam int HOLD_NS = 10;
   localparam int GEN_NS = 30;
   localparam int LATCH_NS = 30;
   localparam int NEWCHK_NS = 32;
   localparam int TMR_W = 4;

   // Least time, rounded up, never below one cycle
   function automatic int cyc_min(input int t_ns);
      int c;
      c = (t_ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min

   // Longest time, rounded down, never below one cycle
   function automatic int cyc_max(input int t_ns);
      int c;
      c = t_ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_max

   localparam int SETUP_CYC = cyc_min(SETUP_NS);
   localparam int HOLD_CYC = cyc_min(HOLD_NS);
   localparam int GEN_CYC = cyc_min(GEN_NS);
   localparam int LATCH_CYC = cyc_min(LATCH_NS);
   localparam int NEWCHK_CYC = cyc_max(NEWCHK_NS);

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_WDATA = 8'h04;
   localparam logic [7:0] OFF_WCHECK = 8'h08;
   localparam logic [7:0] OFF_MDATA = 8'h0c;
   localparam logic [7:0] OFF_MASK = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_RDATA = 8'h18;
   localparam logic [7:0] OFF_RCHECK = 8'h1c;
   localparam int CTRL_GO_BIT = 4;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_SFAULT = 2;
   localparam int ST_MFAULT = 3;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_RMW = 2'h2;
   localparam logic [1:0] OP_DIAG = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [3:0] LANES_OFF = 4'hf;
   localparam logic [3:0] LANES_ON = 4'h0;

   typedef enum logic [3:0] {
      S_IDLE, S_WR_APPLY, S_WR_CHECK, S_RD_APPLY, S_RD_CORRECT,
      S_RD_RELEASE, S_RD_OUT, S_RMW_LATCH, S_RMW_MOD, S_RMW_GEN,
      S_DG_APPLY, S_DG_READ
   } edh_state_t;
endpackage : edh_pkg
`default_nettype wire

// *** verilog/edh_timer.sv ***
`default_nettype none
module edh_timer #(
   parameter int W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } edh_tmr_t;

   edh_tmr_t r;
   edh_tmr_t r_nxt;

   // ------------------------------------------------------------
   // Dwell counter, expires when it reaches zero
   // ------------------------------------------------------------
   always_comb begin
      r_nxt = r;
      if (load) begin
         r_nxt.cnt = load_val;
      end else if (r.cnt != '0) begin
         r_nxt.cnt = r.cnt - W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else if (ce) begin
         r <= r_nxt;
      end
   end

   assign done = (r.cnt == '0);
endmodule : edh_timer
`default_nettype wire

// *** verilog/edh_host.sv ***
`default_nettype none
// Function
// - Host turns data drivers off before writing
// - Host lowers check enable to read check
// - After hold, release bus, then lanes low
// - Correct first, then raise latch enable
// - Modify raises changed lanes, drives those bytes
// - Latch enable after 30 ns, before selects drop
module edh_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic mode_select_upper,
   output logic mode_select_lower,
   output logic [3:0] byte_lane_out_en_n,
   output logic data_port_out_en_n,
   output logic out_latch_en_n,
   output logic check_port_out_en_n,
   input wire logic [31:0] data_port_i,
   output logic [31:0] data_port_o,
   output logic [3:0] data_port_oe,
   input wire logic [6:0] check_port_i,
   output logic [6:0] check_port_o,
   output logic check_port_oe,
   input wire logic single_fault_flag_n,
   input wire logic multi_fault_flag_n
);
   typedef struct packed {
      edh_pkg::edh_state_t st;
      logic [1:0] op;
      logic [31:0] wdata;
      logic [6:0] wcheck;
      logic [31:0] mdata;
      logic [3:0] mask;
      logic [31:0] rdata;
      logic [6:0] rcheck;
      logic busy;
      logic done;
      logic sfault;
      logic mfault;
      logic sel_u;
      logic sel_l;
      logic [3:0] lanes_n;
      logic dp_en_n;
      logic latch_n;
      logic chk_oe_n;
      logic [31:0] dp_o;
      logic [3:0] dp_oe;
      logic [6:0] cp_o;
      logic cp_oe;
      logic awready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rbus;
      logic [1:0] rresp;
   } edh_regs_t;

   edh_regs_t r;
   edh_regs_t r_nxt;
   logic tmr_done;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[8*b +: 8] = val[8*b +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic [edh_pkg::TMR_W-1:0] dwell(input int cyc);
      return edh_pkg::TMR_W'(cyc - 1);
   endfunction : dwell

   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction : word_addr

   edh_timer #(
      .W(edh_pkg::TMR_W)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .load(r_nxt.st != r.st),
      .load_val(dwell(r_nxt.st == edh_pkg::S_RD_APPLY ?
                      edh_pkg::SETUP_CYC :
                      (r_nxt.st == edh_pkg::S_RD_CORRECT ||
                       r_nxt.st == edh_pkg::S_DG_APPLY) ?
                      edh_pkg::HOLD_CYC :
                      r_nxt.st == edh_pkg::S_RMW_LATCH ?
                      edh_pkg::LATCH_CYC :
                      r_nxt.st == edh_pkg::S_RMW_GEN ?
                      edh_pkg::NEWCHK_CYC : edh_pkg::GEN_CYC)),
      .done(tmr_done)
   );

   always_comb begin
      logic start;
      logic fin;
      logic [7:0] a;
      start = 1'b0;
      fin = 1'b0;
      a = '0;
      r_nxt = r;
      // ------------------------------------------------------------
      // Register slave
      // ------------------------------------------------------------
      r_nxt.awready = 1'b0;
      r_nxt.arready = 1'b0;
      if (r.bvalid && s_axi_bready) begin
         r_nxt.bvalid = 1'b0;
      end
      if (r.rvalid && s_axi_rready) begin
         r_nxt.rvalid = 1'b0;
      end
      // Both channels taken together, whichever came first
      if (s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready) begin
         r_nxt.awready = 1'b1;
      end
      if (r.awready) begin
         a = word_addr(s_axi_awaddr);
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp = edh_pkg::RESP_OKAY;
         // Operands are frozen while an operation runs
         unique case (a)
            edh_pkg::OFF_CTRL: begin
               if (s_axi_wstrb[0] && !r.busy) begin
                  r_nxt.op = s_axi_wdata[1:0];
                  start = s_axi_wdata[edh_pkg::CTRL_GO_BIT];
               end
            end
            edh_pkg::OFF_WDATA: begin
               if (!r.busy) begin
                  r_nxt.wdata = merge(r.wdata, s_axi_wdata, s_axi_wstrb);
               end
            end
            edh_pkg::OFF_WCHECK: begin
               if (!r.busy && s_axi_wstrb[0]) begin
                  r_nxt.wcheck = s_axi_wdata[6:0];
               end
            end
            edh_pkg::OFF_MDATA: begin
               if (!r.busy) begin
                  r_nxt.mdata = merge(r.mdata, s_axi_wdata, s_axi_wstrb);
               end
            end
            edh_pkg::OFF_MASK: begin
               if (!r.busy && s_axi_wstrb[0]) begin
                  r_nxt.mask = s_axi_wdata[3:0];
               end
            end
            edh_pkg::OFF_STATUS, edh_pkg::OFF_RDATA,
            edh_pkg::OFF_RCHECK: begin
            end
            default: r_nxt.bresp = edh_pkg::RESP_DECERR;
         endcase
      end
      if (s_axi_arvalid && !r.rvalid && !r.arready) begin
         r_nxt.arready = 1'b1;
      end
      if (r.arready) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp = edh_pkg::RESP_OKAY;
         unique case (word_addr(s_axi_araddr))
            edh_pkg::OFF_CTRL: r_nxt.rbus = {30'h0, r.op};
            edh_pkg::OFF_WDATA: r_nxt.rbus = r.wdata;
            edh_pkg::OFF_WCHECK: r_nxt.rbus = {25'h0, r.wcheck};
            edh_pkg::OFF_MDATA: r_nxt.rbus = r.mdata;
            edh_pkg::OFF_MASK: r_nxt.rbus = {28'h0, r.mask};
            edh_pkg::OFF_STATUS: begin
               r_nxt.rbus = {28'h0, r.mfault, r.sfault, r.done, r.busy};
            end
            edh_pkg::OFF_RDATA: r_nxt.rbus = r.rdata;
            edh_pkg::OFF_RCHECK: r_nxt.rbus = {25'h0, r.rcheck};
            default: begin
               r_nxt.rbus = 32'h0;
               r_nxt.rresp = edh_pkg::RESP_DECERR;
            end
         endcase
      end
      // ------------------------------------------------------------
      // Pin sequencer
      // ------------------------------------------------------------
      unique case (r.st)
         edh_pkg::S_IDLE: begin
            if (start) begin
               r_nxt.busy = 1'b1;
               r_nxt.done = 1'b0;
               r_nxt.sfault = 1'b0;
               r_nxt.mfault = 1'b0;
               r_nxt.dp_o = r.wdata;
               // Lanes are already high in idle: safe to drive
               r_nxt.dp_oe = edh_pkg::LANES_OFF;
               if (r_nxt.op == edh_pkg::OP_WRITE) begin
                  r_nxt.st = edh_pkg::S_WR_APPLY;
               end else begin
                  r_nxt.sel_u = 1'b1;
                  r_nxt.cp_o = r.wcheck;
                  r_nxt.cp_oe = 1'b1;
                  r_nxt.st = edh_pkg::S_RD_APPLY;
               end
            end
         end
         edh_pkg::S_WR_APPLY: begin
            if (tmr_done) begin
               r_nxt.chk_oe_n = 1'b0;
               r_nxt.st = edh_pkg::S_WR_CHECK;
            end
         end
         edh_pkg::S_WR_CHECK: begin
            if (tmr_done) begin
               r_nxt.rcheck = check_port_i;
               fin = 1'b1;
            end
         end
         edh_pkg::S_RD_APPLY: begin
            if (tmr_done) begin
               r_nxt.sfault = !single_fault_flag_n;
               r_nxt.mfault = !multi_fault_flag_n;
               r_nxt.sel_l = 1'b1;
               if (r.op == edh_pkg::OP_DIAG) begin
                  // Check word latches, data stays transparent
                  r_nxt.sel_u = 1'b0;
                  r_nxt.dp_o = r.mdata;
                  r_nxt.st = edh_pkg::S_DG_APPLY;
               end else begin
                  r_nxt.st = edh_pkg::S_RD_CORRECT;
               end
            end
         end
         edh_pkg::S_RD_CORRECT: begin
            // Word and check held through the capture interval
            if (tmr_done) begin
               r_nxt.dp_oe = '0;
               r_nxt.cp_oe = 1'b0;
               r_nxt.st = edh_pkg::S_RD_RELEASE;
            end
         end
         edh_pkg::S_RD_RELEASE: begin
            if (tmr_done) begin
               r_nxt.lanes_n = edh_pkg::LANES_ON;
               r_nxt.chk_oe_n = 1'b0;
               r_nxt.st = edh_pkg::S_RD_OUT;
            end
         end
         edh_pkg::S_RD_OUT: begin
            if (tmr_done) begin
               r_nxt.rdata = data_port_i;
               r_nxt.rcheck = check_port_i;
               if (r.op == edh_pkg::OP_RMW) begin
                  r_nxt.st = edh_pkg::S_RMW_LATCH;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         edh_pkg::S_RMW_LATCH: begin
            // Selects still both high when the latch closes
            if (tmr_done) begin
               r_nxt.latch_n = 1'b1;
               r_nxt.chk_oe_n = 1'b1;
               r_nxt.lanes_n = r.mask;
               r_nxt.st = edh_pkg::S_RMW_MOD;
            end
         end
         edh_pkg::S_RMW_MOD: begin
            if (tmr_done) begin
               r_nxt.dp_o = r.mdata;
               r_nxt.dp_oe = r.mask;
               r_nxt.sel_u = 1'b0;
               r_nxt.sel_l = 1'b0;
               r_nxt.chk_oe_n = 1'b0;
               r_nxt.st = edh_pkg::S_RMW_GEN;
            end
         end
         edh_pkg::S_RMW_GEN: begin
            if (tmr_done) begin
               r_nxt.rdata = data_port_i;
               r_nxt.rcheck = check_port_i;
               fin = 1'b1;
            end
         end
         edh_pkg::S_DG_APPLY: begin
            if (tmr_done) begin
               r_nxt.cp_oe = 1'b0;
               r_nxt.chk_oe_n = 1'b0;
               r_nxt.st = edh_pkg::S_DG_READ;
            end
         end
         edh_pkg::S_DG_READ: begin
            if (tmr_done) begin
               r_nxt.sfault = !single_fault_flag_n;
               r_nxt.mfault = !multi_fault_flag_n;
               r_nxt.rcheck = check_port_i;
               r_nxt.rdata = r.mdata;
               fin = 1'b1;
            end
         end
      endcase
      if (fin) begin
         r_nxt.st = edh_pkg::S_IDLE;
         r_nxt.busy = 1'b0;
         r_nxt.done = 1'b1;
         r_nxt.sel_u = 1'b0;
         r_nxt.sel_l = 1'b0;
         r_nxt.dp_oe = '0;
         r_nxt.cp_oe = 1'b0;
         r_nxt.lanes_n = edh_pkg::LANES_OFF;
         r_nxt.chk_oe_n = 1'b1;
         r_nxt.latch_n = 1'b0;
      end
      r_nxt.dp_en_n = &r_nxt.lanes_n;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.lanes_n <= edh_pkg::LANES_OFF;
         r.dp_en_n <= 1'b1;
         r.chk_oe_n <= 1'b1;
      end else if (ce) begin
         r <= r_nxt;
      end
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.awready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rbus;
   assign s_axi_rresp = r.rresp;
   assign mode_select_upper = r.sel_u;
   assign mode_select_lower = r.sel_l;
   assign byte_lane_out_en_n = r.lanes_n;
   assign data_port_out_en_n = r.dp_en_n;
   assign out_latch_en_n = r.latch_n;
   assign check_port_out_en_n = r.chk_oe_n;
   assign data_port_o = r.dp_o;
   assign data_port_oe = r.dp_oe;
   assign check_port_o = r.cp_o;
   assign check_port_oe = r.cp_oe;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [7:0] s0_age;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s0_age <= '0;
      end else if (ce) begin
         if (!r.sel_l) begin
            s0_age <= '0;
         end else if (s0_age != 8'hff) begin
            s0_age <= s0_age + 8'h01;
         end
      end
   end

   localparam int LATCH_AGE = edh_pkg::LATCH_CYC;

   sequence s_corrected;
      r.sel_u && r.sel_l && (r.lanes_n == edh_pkg::LANES_ON);
   endsequence

   sequence s_write_applied;
      !r.sel_u && !r.sel_l && r.chk_oe_n && (r.dp_oe == 4'hf);
   endsequence

   chk_lanes_off_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (r.dp_oe & ~r.lanes_n) == 4'h0)
      else $error("host drives a byte whose device lane is on");

   chk_write_check_out: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_write_applied ##0 (r.st == edh_pkg::S_WR_APPLY && tmr_done && ce)
      |=> !r.chk_oe_n && !r.cp_oe && !r.sel_l)
      else $error("check enable not lowered after write data");

   chk_release_first: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $fell(r.lanes_n[0]) && r.sel_u && r.sel_l |->
      r.dp_oe == 4'h0 && $past(r.dp_oe) == 4'h0 && !r.cp_oe)
      else $error("lanes enabled before bus released");

   chk_hold_after_s0: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(r.sel_l) && r.sel_u |-> r.dp_oe == 4'hf && r.cp_oe)
      else $error("bus released before capture hold");

   chk_latch_wait: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(r.latch_n) |-> s0_age >= LATCH_AGE && r.sel_u && r.sel_l)
      else $error("output latch closed too early or after selects");

   chk_latch_after_corr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(r.latch_n) |-> $past(r.lanes_n == edh_pkg::LANES_ON) &&
      $past(r.sel_u && r.sel_l))
      else $error("latch closed without a finished correct cycle");

   chk_modify_lanes: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_corrected ##1 $rose(r.latch_n) |->
      r.lanes_n == r.mask && r.dp_oe == 4'h0)
      else $error("modify lanes do not follow the mask");

   chk_mode_order: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(r.sel_l) |-> $past(r.sel_u) && $past(!r.sel_l))
      else $error("lower select rose outside read mode");
endmodule : edh_host
`default_nettype wire

// *** dv/edh_dev_model.sv ***
`default_nettype none
module edh_dev_model (
   input wire logic mode_select_upper,
   input wire logic mode_select_lower,
   input wire logic [3:0] byte_lane_out_en_n,
   input wire logic out_latch_en_n,
   input wire logic check_port_out_en_n,
   input wire logic [31:0] data_bus,
   input wire logic [6:0] check_bus,
   output logic [31:0] dev_data,
   output logic [6:0] dev_check,
   output logic single_fault_flag_n,
   output logic multi_fault_flag_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] din_r, dout_r, fix;
   logic [6:0] cin_r, syn;
   logic [1:0] md;
   // Column codes of weight two or more keep check-bit errors apart
   function automatic logic [5:0] col(input int n);
      logic [5:0] h;
      h = 6'h02;
      for (int i = 0; i <= n; i++) begin
         h = h + 6'h01;
         while ((h & (h - 6'h01)) == 6'h00) h = h + 6'h01;
      end
      return h;
   endfunction : col
   function automatic logic [6:0] gen(input logic [31:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 32; i++) if (d[i]) c = c ^ col(i);
      return {^d ^ ^c, c};
   endfunction : gen
   assign md = {mode_select_upper, mode_select_lower};
   always_latch begin
      if (md != 2'b11) din_r = data_bus;
      if (!mode_select_lower) cin_r = check_bus;
      if (!out_latch_en_n) dout_r = fix;
   end
   always_comb begin
      syn = gen(din_r) ^ cin_r;
      fix = din_r;
      for (int i = 0; i < 32; i++) begin
         if (md == 2'b11 && ^syn && syn[5:0] == col(i)) begin
            fix[i] = ~fix[i];
         end
      end
      single_fault_flag_n = md == 2'b00 || syn == 7'h00;
      multi_fault_flag_n = md == 2'b00 || ^syn || syn == 7'h00;
      dev_data = dout_r;
      dev_check = md == 2'b11 ? syn : md == 2'b01 ? cin_r : gen(din_r);
   end
endmodule : edh_dev_model
`default_nettype wire

// *** dv/edh_host_tb_top.sv ***
`default_nettype none
module edh_host_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, mode_select_upper;
   logic mode_select_lower, data_port_out_en_n, out_latch_en_n;
   logic check_port_out_en_n, check_port_oe;
   logic single_fault_flag_n, multi_fault_flag_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, data_port_i, data_port_o, dev_data;
   logic [3:0] s_axi_wstrb, byte_lane_out_en_n, data_port_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [6:0] check_port_i, check_port_o, dev_check, c0, c1;
   logic [31:0] rdv, st, mw;
   int n_fail, cmp_count, cyc;
   localparam logic [31:0] D0 = 32'h5ac3_1e97;
   localparam logic [31:0] MD = 32'h1234_5678;
   edh_host i_edh_host (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_select_upper,
      .mode_select_lower, .byte_lane_out_en_n, .data_port_out_en_n,
      .out_latch_en_n, .check_port_out_en_n, .data_port_i, .data_port_o,
      .data_port_oe, .check_port_i, .check_port_o, .check_port_oe,
      .single_fault_flag_n, .multi_fault_flag_n);
   edh_dev_model i_edh_dev_model (.mode_select_upper, .mode_select_lower,
      .byte_lane_out_en_n, .out_latch_en_n, .check_port_out_en_n,
      .data_bus(data_port_i), .check_bus(check_port_i), .dev_data,
      .dev_check, .single_fault_flag_n, .multi_fault_flag_n);
   // Undriven lanes show the inverse so a stale value cannot pass
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign data_port_i[8*b+:8] = data_port_oe[b] ? data_port_o[8*b+:8] :
         !byte_lane_out_en_n[b] ? dev_data[8*b+:8] : ~data_port_o[8*b+:8];
   end
   assign check_port_i = check_port_oe ? check_port_o :
      !check_port_out_en_n ? dev_check : ~check_port_o;
   always #50 aclk = ~aclk;
   task automatic wrap_up;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic op(input logic [31:0] wd, input logic [6:0] wc,
         input logic [31:0] m, input logic [3:0] mk, input logic [1:0] c);
      int n;
      wr(edh_pkg::OFF_WDATA, wd);
      wr(edh_pkg::OFF_WCHECK, {25'h0, wc});
      wr(edh_pkg::OFF_MDATA, m);
      wr(edh_pkg::OFF_MASK, {28'h0, mk});
      wr(edh_pkg::OFF_CTRL, 32'h10 | {30'h0, c});
      n = 0;
      st = 32'h0;
      while (st[1] !== 1'b1 && n < 40) begin
         rd(edh_pkg::OFF_STATUS);
         st = rdv;
         n++;
      end
      chk(st & 32'h3, 32'h2);
   endtask : op
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {n_fail, cmp_count, cyc, s_axi_wdata} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk({23'h0, mode_select_upper, mode_select_lower, byte_lane_out_en_n,
         out_latch_en_n, check_port_out_en_n, data_port_out_en_n},
         32'h7b);
      wr(8'h20, 32'h0);
      chk(32'(rsp), 32'(edh_pkg::RESP_DECERR));
      rd(8'h20);
      chk({rdv[29:0], rsp}, 32'(edh_pkg::RESP_DECERR));
      op(D0, 7'h00, 32'h0, 4'h0, edh_pkg::OP_WRITE);
      chk(st & 32'hc, 32'h0);
      rd(edh_pkg::OFF_RCHECK);
      c0 = rdv[6:0];
      op(D0, c0, 32'h0, 4'h0, edh_pkg::OP_READ);
      chk(st & 32'hc, 32'h0);
      rd(edh_pkg::OFF_RCHECK);
      chk(rdv, 32'h0);
      for (int k = 0; k < 4; k++) begin
         op(k < 3 ? D0 ^ (32'h1 << (k * 15)) : D0,
            k < 3 ? c0 : c0 ^ 7'h01, 32'h0, 4'h0, edh_pkg::OP_READ);
         chk(st & 32'hc, 32'h4);
         rd(edh_pkg::OFF_RDATA);
         chk(rdv, D0);
         rd(edh_pkg::OFF_RCHECK);
         chk(32'(rdv == 32'h0), 32'h0);
      end
      op(D0 ^ 32'h3, c0, 32'h0, 4'h0, edh_pkg::OP_READ);
      chk(st & 32'hc, 32'hc);
      op(D0 ^ 32'h20, c0, MD, 4'h5, edh_pkg::OP_RMW);
      mw = (MD & 32'h00ff_00ff) | (D0 & 32'hff00_ff00);
      rd(edh_pkg::OFF_RDATA);
      chk(rdv, mw);
      rd(edh_pkg::OFF_RCHECK);
      c1 = rdv[6:0];
      op(mw, c1, 32'h0, 4'h0, edh_pkg::OP_READ);
      chk(st & 32'hc, 32'h0);
      for (int k = 0; k < 2; k++) begin
         op(D0, c0, D0 ^ (k ? 32'h180 : 32'h80), 4'h0, edh_pkg::OP_DIAG);
         chk(st & 32'hc, k ? 32'hc : 32'h4);
         rd(edh_pkg::OFF_RCHECK);
         chk(rdv, {25'h0, c0});
         rd(edh_pkg::OFF_RDATA);
         chk(rdv, D0 ^ (k ? 32'h180 : 32'h80));
      end
      wrap_up();
   end
endmodule : edh_host_tb_top
`default_nettype wire
